// ### inc/vic_defines.svh
// constants for the vectored interrupt controller: offsets, fields, resets
// assumes a 32-bit register port and a 4-Kbyte decoded window
`ifndef VIC_DEFINES_SVH
`define VIC_DEFINES_SVH
`define VIC_BASE 32'hfffff000
`define VIC_WIN_HI 31
`define VIC_WIN_LO 12
`define OFF_MODE_LO 12'h000
`define OFF_MODE_HI 12'h07c
`define OFF_VEC_LO 12'h080
`define OFF_VEC_HI 12'h0fc
`define OFF_IVR 12'h100
`define OFF_FVR 12'h104
`define OFF_ISR 12'h108
`define OFF_IPR 12'h10c
`define OFF_IMR 12'h110
`define OFF_CISR 12'h114
`define OFF_IECR 12'h120
`define OFF_IDCR 12'h124
`define OFF_ICCR 12'h128
`define OFF_ISCR 12'h12c
`define OFF_EOI 12'h130
`define OFF_SPU 12'h134
`define OFF_DCR 12'h138
`define OFF_FFER 12'h140
`define OFF_FFDR 12'h144
`define OFF_FFSR 12'h148
`define PRIO_LSB 0
`define PRIO_MSB 2
`define TYPE_LSB 5
`define TYPE_MSB 6
`define PROT_BIT 0
`define GLOBAL_MASK_BIT_BIT 1
`define CISR_FAST_BIT 0
`define CISR_NORM_BIT 1
`define RST_WORD 32'h00000000
`define RST_STATE 2'h0
`define EXT_SRC_MASK 32'he0000001
`endif

// ### inc/vic_pkg.sv
// types shared by the vectored interrupt controller files
// assumes vic_defines.svh is available on the include path
package vic_pkg;
  typedef logic [31:0] word_t;
  typedef logic [4:0] src_id_t;
  typedef logic [2:0] prio_t;
  typedef logic [1:0] trig_t;
  // gray coded along idle -> held -> serve
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HELD = 2'b01,
    ST_SERVE = 2'b11
  } svc_state_t;
endpackage

// ### rtl/source_trigger.sv
// one interrupt source: polarity, level or edge sensing, pending latch
// assumes the raw input is synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module source_trigger
  import vic_pkg::*;
#(
  parameter bit EXTERNAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic raw,
  input wire trig_t trig,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic pending
);
  logic lvl;
  logic prev_r;
  logic armed_r;
  logic latch_r;
  logic edge_hit;

  // internal sources never invert; external invert for codes 00 and 01
  assign lvl = raw ^ (EXTERNAL && !trig[1]);
  assign edge_hit = armed_r && lvl && !prev_r;

  // armed only after the first sample, so reset release is not an edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      prev_r <= lvl;
      armed_r <= 1'b1;
    end
  end

  // an edge or set arriving with a clear wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= 1'b0;
    end else if (set_pulse || (trig[0] && edge_hit)) begin
      latch_r <= 1'b1;
    end else if (clr_pulse) begin
      latch_r <= 1'b0;
    end
  end

  // level sources follow the pin, so external ones show it right after reset
  assign pending = trig[0] ? latch_r : lvl;
endmodule
`default_nettype wire

// ### rtl/vectored_irq_controller.sv
// vectored interrupt controller: 32 sources, priority, vectors, masks
// assumes a single-cycle register port and sources synchronous to core_clk
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.svh"
// Contract
// - vector read with nothing pending gives spurious
// - general mask holds both request lines inactive
// - general mask never blocks idle wake-up
// - decode 4-Kbyte window at fixed base
// - thirty-two mode registers, reset zero
// - thirty-two vector registers, reset zero
// - priority field 0 lowest to 7 highest
// - fast source priority is ignored
// - trigger code selects level/edge and polarity
// - internal sources have fixed polarity
// - vector read returns current source vector
// - no current interrupt returns spurious vector
// - fast vector read gives source 0 vector
// - pending resets clear except level sources (all, after reset), which follow their pins
// - four write-only source command registers
// - ones act, zeros leave sources unchanged
// - end command and spurious vector registers
// - any end write finishes current handling
// - debug control and fast redirect registers
// - core state and enable registers read-only
// - core state shows live request lines
module vectored_irq_controller
  import vic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] irq_src,
  output logic normal_request_line_n,
  output logic fast_request_line_n,
  output logic wake_req
);
  //////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_r;
  logic rst_sync_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address decode
  logic hit;
  logic [11:0] off;
  logic wr;
  logic rd;
  logic mode_sel;
  logic vec_sel;
  src_id_t widx;
  assign hit = (reg_addr[`VIC_WIN_HI:`VIC_WIN_LO] ==
                20'(`VIC_BASE >> `VIC_WIN_LO));
  assign off = reg_addr[11:0];
  assign wr = reg_wr && hit;
  assign rd = reg_rd && hit;
  assign mode_sel = (off >= `OFF_MODE_LO) && (off <= `OFF_MODE_HI);
  assign vec_sel = (off >= `OFF_VEC_LO) && (off <= `OFF_VEC_HI);
  assign widx = off[6:2];

  //////////////////////////////////////////////////////////////////////////
  // configuration storage
  word_t mode_r [32];
  word_t vec_r [32];
  word_t spu_r;
  logic [1:0] dbg_r;
  logic [31:0] en_r;
  logic [31:0] ff_r;
  logic prot;
  logic global_mask_bit;
  assign prot = dbg_r[`PROT_BIT];
  assign global_mask_bit = dbg_r[`GLOBAL_MASK_BIT_BIT];

  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      for (int i = 0; i < 32; i++) begin
        mode_r[i] <= `RST_WORD;
        vec_r[i] <= `RST_WORD;
      end
    end else if (wr && mode_sel) begin
      mode_r[widx] <= `RST_WORD;
      mode_r[widx][`TYPE_MSB:`TYPE_LSB] <= reg_wdata[`TYPE_MSB:`TYPE_LSB];
      mode_r[widx][`PRIO_MSB:`PRIO_LSB] <= reg_wdata[`PRIO_MSB:`PRIO_LSB];
    end else if (wr && vec_sel) begin
      vec_r[widx] <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      spu_r <= `RST_WORD;
      dbg_r <= `RST_STATE;
    end else if (wr && off == `OFF_SPU) begin
      spu_r <= reg_wdata;
    end else if (wr && off == `OFF_DCR) begin
      dbg_r <= reg_wdata[1:0];
    end
  end

  // zeros leave bits alone; enable and disable never meet in one cycle
  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      en_r <= `RST_WORD;
      ff_r <= `RST_WORD;
    end else if (wr) begin
      if (off == `OFF_IECR) begin
        en_r <= en_r | reg_wdata;
      end
      if (off == `OFF_IDCR) begin
        en_r <= en_r & ~reg_wdata;
      end
      // source 0 is the fast source already, redirect has no meaning there
      if (off == `OFF_FFER) begin
        ff_r <= (ff_r | reg_wdata) & 32'hfffffffe;
      end
      if (off == `OFF_FFDR) begin
        ff_r <= ff_r & ~reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sources
  logic [31:0] pend;
  logic [31:0] ack_clr;
  logic [31:0] set_cmd;
  logic [31:0] clr_cmd;
  assign set_cmd = (wr && off == `OFF_ISCR) ? reg_wdata : 32'h0;
  assign clr_cmd = (wr && off == `OFF_ICCR) ? reg_wdata : 32'h0;

  for (genvar g = 0; g < 32; g++) begin : g_src
    source_trigger #(
      .EXTERNAL(1'(`EXT_SRC_MASK >> g))
    ) u_src (
      .core_clk(core_clk),
      .rst_n(rst_sync_r),
      .raw(irq_src[g]),
      .trig(mode_r[g][`TYPE_MSB:`TYPE_LSB]),
      .set_pulse(set_cmd[g]),
      .clr_pulse(clr_cmd[g] | ack_clr[g]),
      .pending(pend[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // priority resolution over the normal sources
  logic [31:0] live;
  logic cand_valid;
  src_id_t cand_id;
  prio_t cand_prio;
  assign live = pend & en_r;

  // source 0 is skipped: its priority field never ranks; ties go low index
  always_comb begin
    cand_valid = 1'b0;
    cand_id = 5'h00;
    cand_prio = 3'h0;
    for (int i = 31; i >= 1; i--) begin
      if (live[i] && !ff_r[i] &&
          (!cand_valid ||
           mode_r[i][`PRIO_MSB:`PRIO_LSB] >= cand_prio)) begin
        cand_valid = 1'b1;
        cand_id = 5'(i);
        cand_prio = mode_r[i][`PRIO_MSB:`PRIO_LSB];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // handling state
  svc_state_t state_r;
  src_id_t cur_id_r;
  src_id_t held_id_r;
  prio_t cur_prio_r;
  logic avail;
  logic ivr_rd;
  logic ivr_wr;
  logic fvr_rd;
  logic take;
  src_id_t take_id;
  logic fast_live;

  // no stack: a higher level preempts the current one but is not nested
  assign avail = cand_valid &&
                 (state_r != ST_SERVE || cand_prio > cur_prio_r);
  assign ivr_rd = rd && off == `OFF_IVR;
  assign ivr_wr = wr && off == `OFF_IVR;
  assign fvr_rd = rd && off == `OFF_FVR;
  assign take = (ivr_rd && avail && !prot) ||
                (ivr_wr && prot && state_r == ST_HELD);
  assign take_id = (state_r == ST_HELD) ? held_id_r : cand_id;
  assign fast_live = live[0] || (|(live & ff_r));

  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= ST_IDLE;
      cur_id_r <= 5'h00;
      held_id_r <= 5'h00;
      cur_prio_r <= 3'h0;
    end else if (wr && off == `OFF_EOI) begin
      state_r <= ST_IDLE;
    end else if (take) begin
      state_r <= ST_SERVE;
      cur_id_r <= take_id;
      cur_prio_r <= mode_r[take_id][`PRIO_MSB:`PRIO_LSB];
    end else begin
      case (state_r)
        ST_IDLE, ST_SERVE: begin
          if (ivr_rd && avail && prot) begin
            state_r <= ST_HELD;
            held_id_r <= cand_id;
          end
        end
        ST_HELD: begin
          if (ivr_rd && avail) begin
            held_id_r <= cand_id;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // acknowledge drops edge latches; level sources clear at their origin
  always_comb begin
    ack_clr = 32'h0;
    if (take && mode_r[take_id][`TYPE_LSB]) begin
      ack_clr[take_id] = 1'b1;
    end
    if (fvr_rd && live[0] && mode_r[0][`TYPE_LSB]) begin
      ack_clr[0] = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // request lines, active low to the core
  logic norm_act;
  logic fast_act;
  assign norm_act = avail && !global_mask_bit;
  assign fast_act = fast_live && !global_mask_bit;
  assign normal_request_line_n = !norm_act;
  assign fast_request_line_n = !fast_act;
  // wake ignores the general mask so idle cores still resume
  assign wake_req = |live;

  //////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe
  word_t rd_nxt;
  always_comb begin
    rd_nxt = `RST_WORD;
    if (mode_sel) begin
      rd_nxt = mode_r[widx];
    end else if (vec_sel) begin
      rd_nxt = vec_r[widx];
    end else begin
      case (off)
        `OFF_IVR: rd_nxt = avail ? vec_r[cand_id] : spu_r;
        `OFF_FVR: rd_nxt = fast_live ? vec_r[0] : spu_r;
        `OFF_ISR: rd_nxt = {27'h0, cur_id_r};
        `OFF_IPR: rd_nxt = pend;
        `OFF_IMR: rd_nxt = en_r;
        `OFF_CISR: rd_nxt = {30'h0, norm_act, fast_act};
        `OFF_SPU: rd_nxt = spu_r;
        `OFF_DCR: rd_nxt = {30'h0, dbg_r};
        `OFF_FFSR: rd_nxt = ff_r;
        default: rd_nxt = `RST_WORD;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reg_rdata <= `RST_WORD;
    end else if (rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= `RST_WORD;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_spurious;
    @(posedge core_clk) disable iff (!rst_sync_r)
    ivr_rd && !avail |=> reg_rdata == $past(spu_r);
  endproperty
  a_spurious: assert property (p_spurious)
    else $error("spurious vector not returned");

  property p_global_mask_bit;
    @(posedge core_clk) disable iff (!rst_sync_r)
    global_mask_bit |-> normal_request_line_n && fast_request_line_n;
  endproperty
  a_global_mask_bit: assert property (p_global_mask_bit)
    else $error("request line active under general mask");

  property p_wake;
    @(posedge core_clk) disable iff (!rst_sync_r)
    (|(pend & en_r)) |-> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake lost");

  property p_ivr;
    @(posedge core_clk) disable iff (!rst_sync_r)
    ivr_rd && avail |=> reg_rdata == vec_r[$past(cand_id)];
  endproperty
  a_ivr: assert property (p_ivr)
    else $error("wrong current vector");

  property p_fvr;
    @(posedge core_clk) disable iff (!rst_sync_r)
    fvr_rd |=> reg_rdata == ($past(fast_live) ? $past(vec_r[0])
                                              : $past(spu_r));
  endproperty
  a_fvr: assert property (p_fvr)
    else $error("wrong fast vector");

  property p_enable;
    @(posedge core_clk) disable iff (!rst_sync_r)
    wr && off == `OFF_IECR |=> (en_r & $past(reg_wdata)) == $past(reg_wdata);
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable command lost");

  property p_eoi;
    @(posedge core_clk) disable iff (!rst_sync_r)
    wr && off == `OFF_EOI |=> state_r == ST_IDLE;
  endproperty
  a_eoi: assert property (p_eoi)
    else $error("end command did not finish handling");

  property p_cisr;
    @(posedge core_clk) disable iff (!rst_sync_r)
    rd && off == `OFF_CISR |=>
      reg_rdata[`CISR_NORM_BIT] == !$past(normal_request_line_n) &&
      reg_rdata[`CISR_FAST_BIT] == !$past(fast_request_line_n);
  endproperty
  a_cisr: assert property (p_cisr)
    else $error("core state mismatch");

  property p_reserved;
    @(posedge core_clk) disable iff (!rst_sync_r)
    rd && (off == 12'h118 || off == 12'h13c || off >= 12'h14c) |=>
      reg_rdata == 32'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved offset read nonzero");

  c_take: cover property (@(posedge core_clk) disable iff (!rst_sync_r)
    take ##[1:20] (wr && off == `OFF_EOI));
  c_spur: cover property (@(posedge core_clk) disable iff (!rst_sync_r)
    ivr_rd && !avail);
  c_fast: cover property (@(posedge core_clk) disable iff (!rst_sync_r)
    fast_act && |(live & ff_r));
  c_held: cover property (@(posedge core_clk) disable iff (!rst_sync_r)
    state_r == ST_HELD ##[1:10] take);
endmodule
`default_nettype wire

// ### tb/core_model.sv
// core-side model: watches both request lines and the wake-up level
// assumes active-low request lines and a core that sleeps until woken
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic normal_request_line_n,
  input wire logic fast_request_line_n,
  input wire logic wake_req,
  output logic irq_seen,
  output logic fiq_seen,
  output logic awake
);
  // sticky flags so a one-cycle request is never missed by the bench
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_seen <= 1'b0;
      fiq_seen <= 1'b0;
      awake <= 1'b0;
    end else begin
      if (!normal_request_line_n) irq_seen <= 1'b1;
      if (!fast_request_line_n) fiq_seen <= 1'b1;
      // idle core leaves sleep on the wake level alone
      if (wake_req) awake <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### tb/vectored_interrupt_controller_regs_bench.sv
// self-checking bench for the vectored interrupt controller
// assumes the register port contract: read data one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
`include "vic_defines.svh"
module vectored_interrupt_controller_regs_bench
  import vic_pkg::*;
;
  logic core_clk, rst_n, reg_wr, reg_rd, rd_pend;
  logic normal_request_line_n, fast_request_line_n, wake_req;
  logic irq_seen, fiq_seen, awake;
  word_t reg_addr, reg_wdata, reg_rdata, irq_src, spu, v5, v9, vf, d;
  word_t exp_q[$];
  string name_q[$];
  int error_cnt, checks, cyc, seed, i;

  vectored_irq_controller u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_src(irq_src),
    .normal_request_line_n(normal_request_line_n),
    .fast_request_line_n(fast_request_line_n), .wake_req(wake_req)
  );
  core_model u_core (
    .core_clk(core_clk), .rst_n(rst_n),
    .normal_request_line_n(normal_request_line_n),
    .fast_request_line_n(fast_request_line_n), .wake_req(wake_req),
    .irq_seen(irq_seen), .fiq_seen(fiq_seen), .awake(awake)
  );

  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input word_t seen, input word_t exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic word_t ad(input logic [11:0] o);
    return `VIC_BASE | {20'h0, o};
  endfunction

  task automatic wr(input word_t a, input word_t v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= v;
  endtask

  // the expectation is queued here and compared by the watcher below
  task automatic rd(input string nm, input word_t a, input word_t e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    exp_q.push_back(e);
    name_q.push_back(nm);
  endtask

  task automatic idle(input int n);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n - 1) @(posedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (rd_pend) chk(name_q.pop_front(), reg_rdata, exp_q.pop_front());
    rd_pend = reg_rd;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 39453;
    error_cnt = 0;
    checks = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    // external sources idle high so none is pending after reset
    irq_src = 32'he0000001;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    idle(3);
    rd("mode0", ad(12'h000), 32'h0);
    rd("mode31", ad(12'h07c), 32'h0);
    rd("vec0", ad(12'h080), 32'h0);
    rd("vec31", ad(12'h0fc), 32'h0);
    rd("pend", ad(12'h10c), 32'h0);
    rd("enab", ad(12'h110), 32'h0);
    rd("core", ad(12'h114), 32'h0);
    rd("spu", ad(12'h134), 32'h0);
    rd("dbg", ad(12'h138), 32'h0);
    rd("ffst", ad(12'h148), 32'h0);
    idle(2);
    $display("test reset values done");

    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      wr(ad(12'h000 + 12'(4 * (i * 9 % 32))), d);
      rd("mode rw", ad(12'h000 + 12'(4 * (i * 9 % 32))), d & 32'h67);
      wr(ad(12'h080 + 12'(4 * (i * 9 % 32))), ~d);
      rd("vec rw", ad(12'h080 + 12'(4 * (i * 9 % 32))), ~d);
      wr(ad(12'h000 + 12'(4 * (i * 9 % 32))), 32'h0);
    end
    spu = $random(seed);
    wr(ad(12'h134), spu);
    rd("spurious", ad(12'h100), spu);
    rd("fast spurious", ad(12'h104), spu);
    wr(ad(12'h130), spu);
    idle(2);
    $display("test spurious done");

    v5 = $random(seed);
    v9 = $random(seed);
    wr(ad(12'h014), 32'h3);
    wr(ad(12'h024), 32'h6);
    wr(ad(12'h094), v5);
    wr(ad(12'h0a4), v9);
    wr(ad(12'h120), 32'h220);
    idle(1);
    irq_src[5] <= 1'b1;
    irq_src[9] <= 1'b1;
    idle(2);
    chk("normal line", 32'(normal_request_line_n), 32'h0);
    chk("core irq", 32'(irq_seen), 32'h1);
    rd("core state", ad(12'h114), 32'h2);
    rd("enabled", ad(12'h110), 32'h220);
    rd("best vector", ad(12'h100), v9);
    rd("source id", ad(12'h108), 32'd9);
    idle(1);
    irq_src[9] <= 1'b0;
    wr(ad(12'h130), $random(seed));
    rd("next vector", ad(12'h100), v5);
    wr(ad(12'h130), 32'h0);
    wr(ad(12'h124), 32'h220);
    rd("disabled", ad(12'h110), 32'h0);
    rd("none left", ad(12'h100), spu);
    idle(1);
    irq_src[5] <= 1'b0;
    $display("test priority done");

    vf = $random(seed);
    wr(ad(12'h000), 32'h7);
    wr(ad(12'h080), vf);
    wr(ad(12'h120), 32'h1);
    idle(1);
    irq_src[0] <= 1'b0;
    idle(2);
    chk("fast line", 32'(fast_request_line_n), 32'h0);
    rd("core fast", ad(12'h114), 32'h1);
    rd("fast vector", ad(12'h104), vf);
    wr(ad(12'h138), 32'h2);
    idle(2);
    chk("masked fast", 32'(fast_request_line_n), 32'h1);
    chk("wake", 32'(wake_req), 32'h1);
    chk("core woke", 32'(awake & fiq_seen), 32'h1);
    rd("core masked", ad(12'h114), 32'h0);
    rd("dbg rw", ad(12'h138), 32'h2);
    wr(ad(12'h138), 32'h0);
    wr(ad(12'h124), 32'h1);
    idle(1);
    irq_src[0] <= 1'b1;
    rd("fast gone", ad(12'h104), spu);
    idle(2);
    $display("test fast and mask done");

    // internal source 12 pulsed under each trigger code
    for (i = 0; i < 4; i++) begin
      wr(ad(12'h030), 32'(i) << 5);
      idle(1);
      irq_src[12] <= 1'b1;
      idle(2);
      irq_src[12] <= 1'b0;
      idle(2);
      rd("trigger", ad(12'h10c), i[0] ? 32'h1000 : 32'h0);
      wr(ad(12'h128), 32'h1000);
      idle(2);
    end
    wr(ad(12'h030), 32'h60);
    wr(ad(12'h12c), 32'h1000);
    rd("set cmd", ad(12'h10c), 32'h1000);
    wr(ad(12'h128), 32'h0);
    rd("zero clear", ad(12'h10c), 32'h1000);
    wr(ad(12'h128), 32'h1000);
    rd("clear cmd", ad(12'h10c), 32'h0);
    $display("test triggers and commands done");

    // a redirected source leaves the priority logic for the fast line
    wr(ad(12'h120), 32'h20);
    wr(ad(12'h140), 32'h21);
    idle(1);
    irq_src[5] <= 1'b1;
    rd("ffsr", ad(12'h148), 32'h20);
    rd("core redirect", ad(12'h114), 32'h1);
    rd("redirect fvr", ad(12'h104), vf);
    rd("redirect ivr", ad(12'h100), spu);
    wr(ad(12'h144), 32'h20);
    rd("ffsr off", ad(12'h148), 32'h0);
    rd("unforced ivr", ad(12'h100), v5);
    wr(ad(12'h130), 32'h0);
    // protect mode: a read alone must not acknowledge, the write does
    wr(ad(12'h138), 32'h1);
    rd("protect ivr", ad(12'h100), v5);
    rd("protect held", ad(12'h114), 32'h2);
    wr(ad(12'h100), 32'h0);
    rd("protect taken", ad(12'h114), 32'h0);
    wr(ad(12'h138), 32'h0);
    wr(ad(12'h130), 32'h0);
    wr(ad(12'h124), 32'h20);
    idle(1);
    irq_src[5] <= 1'b0;
    idle(2);
    $display("test redirect and protect done");

    wr(ad(12'h118), $random(seed));
    rd("reserved", ad(12'h118), 32'h0);
    rd("reserved hole", ad(12'h13c), 32'h0);
    rd("outside", 32'h00000100, 32'h0);
    rd("still spu", ad(12'h134), spu);
    idle(3);
    $display("test decode done");
    close_out();
  end
endmodule
`default_nettype wire
